/* File: core/cic_pkg.sv */
// Constants and types shared by the CAN interrupt and mode control block
package cic_pkg;

    // ==========================================================
    // Register bus
    localparam int ADDR_W = 3;
    localparam int DATA_W = 8;
    localparam logic [2:0] OFF_CTRL0 = 3'h0;
    localparam logic [2:0] OFF_CTRL1 = 3'h1;
    localparam logic [2:0] OFF_RFLG = 3'h2;
    localparam logic [2:0] OFF_RIER = 3'h3;
    localparam logic [2:0] OFF_TFLG = 3'h4;
    localparam logic [2:0] OFF_TIER = 3'h5;

    // ==========================================================
    // Control register fields
    localparam int BIT_INIT_REQ = 0;
    localparam int BIT_SLEEP_REQ = 1;
    localparam int BIT_WAKE_EN = 2;
    localparam int BIT_INIT_ACK = 0;
    localparam int BIT_SLEEP_ACK = 1;
    localparam int BIT_MOD_EN = 7;

    // ==========================================================
    // Receive flag and enable register fields, transmit buffer count
    localparam int BIT_RX_FULL = 0;
    localparam int BIT_OVERRUN = 1;
    localparam int POS_TX_ERROR_STATE_FIELD = 2;
    localparam int POS_RX_ERROR_STATE_FIELD = 4;
    localparam int BIT_STATUS_CHG = 6;
    localparam int BIT_WAKE = 7;
    localparam int TX_BUFS = 3;

    // ==========================================================
    // Values after reset
    localparam logic RST_INIT_REQ = 1'b1;
    localparam logic RST_SLEEP_REQ = 1'b0;
    localparam logic RST_WAKE_EN = 1'b0;
    localparam logic RST_MOD_EN = 1'b0;
    localparam logic [7:0] RST_RIER = 8'h00;
    localparam logic [2:0] RST_TIER = 3'h0;
    localparam logic [7:0] RST_DATA = 8'h00;

    // ==========================================================
    // Error counter thresholds
    localparam logic [8:0] CNT_WARN = 9'h060;
    localparam logic [8:0] CNT_PASSIVE = 9'h080;
    localparam logic [8:0] CNT_BUSOFF = 9'h100;

    typedef enum logic [1:0] {
        ERR_OK = 2'b00,
        ERR_WARNING = 2'b01,
        ERR_PASSIVE = 2'b10,
        ERR_BUSOFF = 2'b11
    } cic_err_state_type;

    // Maps an error counter onto its bus state
    function automatic cic_err_state_type cic_err_state(input logic [8:0] cnt);
        if (cnt >= CNT_BUSOFF) begin
            return ERR_BUSOFF;
        end else if (cnt >= CNT_PASSIVE) begin
            return ERR_PASSIVE;
        end else if (cnt >= CNT_WARN) begin
            return ERR_WARNING;
        end
        return ERR_OK;
    endfunction : cic_err_state

endpackage : cic_pkg

/* File: core/cic_flag_bank.sv */
// Bank of sticky status flags with write-one clear blocked by a live cause
module cic_flag_bank
    import cic_pkg::*;
#(
    parameter int WIDTH = 1
) (
    // Clock and reset
    input wire logic clk_sys,
    input wire logic rst,
    // Flag control
    input wire logic [WIDTH-1:0] setEvent,
    input wire logic [WIDTH-1:0] causeActive,
    input wire logic [WIDTH-1:0] clearReq,
    input wire logic forceClear,
    // Flag state
    output logic [WIDTH-1:0] flag
);

    logic [WIDTH-1:0] next_flag;

    // ==========================================================
    // Force clear wins; otherwise set wins over a write-one clear, which is void while its cause holds
    always_comb begin
        if (forceClear) begin
            next_flag = '0;
        end else begin
            next_flag = setEvent
                | (flag & ~(clearReq & ~causeActive)); // [RULE_06] [RULE_07]
        end
    end

    always_ff @(posedge clk_sys) begin
        if (rst) begin
            flag <= '0;
        end else begin
            flag <= next_flag;
        end
    end

    a_clear_blocked: assert property (@(posedge clk_sys) // [RULE_07]
        disable iff (rst)
        (!forceClear && |(flag & causeActive)) |=>
        ((flag & $past(flag & causeActive)) == $past(flag & causeActive)))
        else $error("Flag cleared while its cause was present");

endmodule : cic_flag_bank

/* File: core/cic_top.sv */
// CAN interrupt flags, wake-up gating and sleep/init mode handshakes
// Overview of operation
// RULE_01: Error interrupt on receive FIFO overrun or error state change.
// RULE_02: Flag status change when error counters enter warning, passive, bus-off.
// RULE_03: Transmitter and receiver states shown in separate receive flag fields.
// RULE_04: Each interrupt tied to flags in receive or transmit flag register.
// RULE_05: Interrupt stays asserted while any associated flag is set.
// RULE_06: Writing one clears a flag; writing zero leaves it.
// RULE_07: Clear has no effect while the flag's cause is still present.
// RULE_08: Software clears flags in the handler to acknowledge interrupts.
// RULE_09: Software writes one only to the causing flag, no read-modify-write.
// RULE_10: Wake interrupt needs prior sleep, bus wake enable and interrupt enable.
// RULE_11: Start-up: set module enable, configure in init, clear init request.
// RULE_12: Reconfigure: request sleep, wait acknowledge given only on idle bus.
// RULE_13: Then request init, await acknowledge, configure, clear init request.
// RULE_14: Error interrupt from status-change and overrun flags, each enabled.
// RULE_15: Sleep active only while sleep request and acknowledge are both set.
// RULE_16: Init acknowledge only after all internal domains are in init mode.
// RULE_17: Wake flag set on bus activity in sleep when bus wake enabled.
// RULE_18: Error request is OR of enabled status-change and enabled overrun.
module cic_top
    import cic_pkg::*;
(
    // Clock and reset
    input wire logic clk_sys,
    input wire logic rst,
    // Register port
    input wire logic [ADDR_W-1:0] regAddr,
    input wire logic [DATA_W-1:0] regWrData,
    input wire logic regWrite,
    input wire logic regRead,
    output logic [DATA_W-1:0] regRdData,
    // Protocol core status
    input wire logic rxFifoFull,
    input wire logic rxFifoOverrun,
    input wire logic [TX_BUFS-1:0] txBufEmpty,
    input wire logic [8:0] txErrCount,
    input wire logic [7:0] rxErrCount,
    input wire logic busIdle,
    input wire logic busActivity,
    input wire logic coreInInit,
    input wire logic powerDown,
    // Mode outputs
    output logic moduleEnable,
    output logic initModeActive,
    output logic sleepModeActive,
    // Interrupts
    output logic irqWake,
    output logic irqError,
    output logic irqRx,
    output logic irqTx,
    output logic wakeFromPowerDown
);

    logic initReq, sleepReq, wakeEn, modEn, initSeen, initAck, sleepAck;
    logic next_initReq, next_sleepReq, next_wakeEn, next_modEn;
    logic next_initSeen, next_initAck, next_sleepAck;
    logic [7:0] rier, next_rier;
    logic [TX_BUFS-1:0] tier, next_tier;
    cic_err_state_type txState, rxState, next_txState, next_rxState;
    logic sleepActive, wakeSet, cscSet, wrCtrl0, wrRflg, wrTflg;
    logic [3:0] rxSet, rxCause, rxClear, rxFlag;
    logic [TX_BUFS-1:0] txFlag;
    logic [DATA_W-1:0] next_rdData;
    logic next_irqWake, next_irqError, next_irqRx, next_irqTx, next_wakePd;

    assign wrCtrl0 = regWrite && regAddr == OFF_CTRL0;
    assign wrRflg = regWrite && regAddr == OFF_RFLG;
    assign wrTflg = regWrite && regAddr == OFF_TFLG;
    assign sleepActive = sleepReq && sleepAck; // [RULE_15]

    // ==========================================================
    // Mode control and handshakes
    always_comb begin
        next_initReq = initReq;
        next_sleepReq = sleepReq;
        next_wakeEn = wakeEn;
        next_modEn = modEn;
        next_rier = rier;
        next_tier = tier;
        if (wrCtrl0) begin
            next_wakeEn = regWrData[BIT_WAKE_EN];
            // Requests may only be dropped once acknowledged
            if (regWrData[BIT_INIT_REQ] || initAck) begin
                next_initReq = regWrData[BIT_INIT_REQ];
            end
            if (regWrData[BIT_SLEEP_REQ] || sleepActive) begin
                next_sleepReq = regWrData[BIT_SLEEP_REQ];
            end
        end
        if (regWrite && regAddr == OFF_CTRL1) begin
            next_modEn = regWrData[BIT_MOD_EN];
        end
        if (regWrite && regAddr == OFF_RIER) begin
            next_rier = regWrData;
        end
        if (regWrite && regAddr == OFF_TIER) begin
            next_tier = regWrData[TX_BUFS-1:0];
        end
        // Bus activity ends sleep when bus wake-up is enabled
        if (wakeSet) begin
            next_sleepReq = 1'b0;
        end
        // Init mode puts the interrupt logic back to defaults
        if (initAck) begin
            next_sleepReq = RST_SLEEP_REQ;
            next_rier = RST_RIER;
            next_tier = RST_TIER;
        end
        // Sleep acknowledged only with an idle bus
        next_sleepAck = sleepReq && !wakeSet
            && (sleepAck || busIdle); // [RULE_12]
        // Bus-side stage plus core domain must both be in init
        next_initSeen = initReq;
        next_initAck = initReq && initSeen && coreInInit; // [RULE_16]
    end

    always_ff @(posedge clk_sys) begin
        if (rst) begin
            initReq <= RST_INIT_REQ;
            sleepReq <= RST_SLEEP_REQ;
            wakeEn <= RST_WAKE_EN;
            modEn <= RST_MOD_EN;
            rier <= RST_RIER;
            tier <= RST_TIER;
            sleepAck <= 1'b0;
            initSeen <= 1'b0;
            initAck <= 1'b0;
        end else begin
            initReq <= next_initReq;
            sleepReq <= next_sleepReq;
            wakeEn <= next_wakeEn;
            modEn <= next_modEn;
            rier <= next_rier;
            tier <= next_tier;
            sleepAck <= next_sleepAck;
            initSeen <= next_initSeen;
            initAck <= next_initAck;
        end
    end

    // ==========================================================
    // Error state tracking
    always_comb begin
        next_txState = cic_err_state(txErrCount);
        next_rxState = cic_err_state({1'b0, rxErrCount});
        cscSet = (next_txState != txState && next_txState != ERR_OK)
            || (next_rxState != rxState
            && next_rxState != ERR_OK); // [RULE_02]
    end

    always_ff @(posedge clk_sys) begin
        if (rst) begin
            txState <= ERR_OK;
            rxState <= ERR_OK;
        end else begin
            txState <= next_txState;
            rxState <= next_rxState;
        end
    end

    // ==========================================================
    // Status flags
    assign wakeSet = sleepActive && wakeEn && busActivity; // [RULE_17]
    assign rxSet = {wakeSet, cscSet, rxFifoOverrun, rxFifoFull}; // [RULE_01]
    assign rxCause = {busActivity, 1'b0, rxFifoOverrun, rxFifoFull};
    assign rxClear = wrRflg ? {regWrData[BIT_WAKE], regWrData[BIT_STATUS_CHG],
        regWrData[BIT_OVERRUN], regWrData[BIT_RX_FULL]} : 4'h0;

    cic_flag_bank #(
        .WIDTH(4)
    ) u_rx_flags (
        .clk_sys(clk_sys),
        .rst(rst),
        .setEvent(rxSet),
        .causeActive(rxCause),
        .clearReq(rxClear),
        .forceClear(initAck),
        .flag(rxFlag)
    );

    cic_flag_bank #(
        .WIDTH(TX_BUFS)
    ) u_tx_flags (
        .clk_sys(clk_sys),
        .rst(rst),
        .setEvent(txBufEmpty),
        .causeActive(txBufEmpty),
        .clearReq(wrTflg ? regWrData[TX_BUFS-1:0] : {TX_BUFS{1'b0}}),
        .forceClear(initAck),
        .flag(txFlag)
    );

    // ==========================================================
    // Interrupt requests and read data
    always_comb begin
        next_irqWake = rxFlag[3] && rier[BIT_WAKE]; // [RULE_10]
        next_irqError = (rxFlag[2] && rier[BIT_STATUS_CHG])
            || (rxFlag[1] && rier[BIT_OVERRUN]); // [RULE_14] [RULE_18]
        next_irqRx = rxFlag[0] && rier[BIT_RX_FULL]; // [RULE_04] [RULE_05]
        next_irqTx = |(txFlag & tier); // [RULE_04] [RULE_05]
        next_wakePd = powerDown && next_irqWake && wakeEn; // [RULE_10]
        next_rdData = RST_DATA;
        if (regRead) begin
            unique case (regAddr)
                OFF_CTRL0: next_rdData = {5'h00, wakeEn, sleepReq, initReq};
                OFF_CTRL1: next_rdData = {modEn, 5'h00, sleepAck, initAck};
                OFF_RFLG: next_rdData = {rxFlag[3], rxFlag[2], rxState,
                    txState, rxFlag[1], rxFlag[0]}; // [RULE_03]
                OFF_RIER: next_rdData = rier;
                OFF_TFLG: next_rdData = {5'h00, txFlag};
                OFF_TIER: next_rdData = {5'h00, tier};
                default: next_rdData = RST_DATA;
            endcase
        end
    end

    always_ff @(posedge clk_sys) begin
        if (rst) begin
            irqWake <= 1'b0;
            irqError <= 1'b0;
            irqRx <= 1'b0;
            irqTx <= 1'b0;
            wakeFromPowerDown <= 1'b0;
            regRdData <= RST_DATA;
            moduleEnable <= RST_MOD_EN;
            initModeActive <= 1'b0;
            sleepModeActive <= 1'b0;
        end else begin
            irqWake <= next_irqWake;
            irqError <= next_irqError;
            irqRx <= next_irqRx;
            irqTx <= next_irqTx;
            wakeFromPowerDown <= next_wakePd;
            regRdData <= next_rdData;
            moduleEnable <= modEn;
            initModeActive <= initAck;
            sleepModeActive <= sleepActive;
        end
    end

    // ==========================================================
    // Checks
    sequence s_asleep;
        sleepReq && sleepAck && wakeEn;
    endsequence

    sequence s_activity;
        busActivity && !initAck;
    endsequence

    a_wake_flag_set: assert property (@(posedge clk_sys) // [RULE_17]
        disable iff (rst)
        (s_asleep and s_activity) |=> rxFlag[3]
        ##1 irqWake == rier[BIT_WAKE])
        else $error("Wake flag or request missing after bus activity in sleep");

    a_wake_needs_sleep: assert property (@(posedge clk_sys) // [RULE_10]
        disable iff (rst)
        $rose(rxFlag[3]) |-> $past(sleepActive && wakeEn))
        else $error("Wake flag set outside sleep");

    a_error_irq_or: assert property (@(posedge clk_sys) // [RULE_18]
        disable iff (rst)
        ##1 irqError == $past((rxFlag[2] && rier[BIT_STATUS_CHG])
        || (rxFlag[1] && rier[BIT_OVERRUN])))
        else $error("Error request does not follow enabled flags");

    a_status_change: assert property (@(posedge clk_sys) // [RULE_02]
        disable iff (rst)
        (cscSet && !initAck) |=> rxFlag[2])
        else $error("Status change not flagged");

    a_overrun_hold: assert property (@(posedge clk_sys) // [RULE_07]
        disable iff (rst)
        (rxFlag[1] && rxFifoOverrun && !initAck) |=> rxFlag[1])
        else $error("Overrun flag cleared while overrun present");

    a_write_clear: assert property (@(posedge clk_sys) // [RULE_06]
        disable iff (rst)
        (wrRflg && regWrData[BIT_OVERRUN] && !rxFifoOverrun) |=> !rxFlag[1])
        else $error("Write one did not clear overrun flag");

    a_zero_keeps: assert property (@(posedge clk_sys) // [RULE_06]
        disable iff (rst)
        (wrTflg && txFlag[0] && !regWrData[0] && !initAck) |=> txFlag[0])
        else $error("Writing zero cleared a transmit flag");

    a_irq_level: assert property (@(posedge clk_sys) // [RULE_05]
        disable iff (rst)
        (txFlag[0] && tier[0])[*2] |=> irqTx)
        else $error("Transmit request dropped while flag set");

    a_init_ack_wait: assert property (@(posedge clk_sys) // [RULE_16]
        disable iff (rst)
        $rose(initReq) |=> !initAck)
        else $error("Init acknowledge came too early");

    a_init_ack_core: assert property (@(posedge clk_sys) // [RULE_16]
        disable iff (rst)
        $rose(initAck) |-> $past(coreInInit && initSeen))
        else $error("Init acknowledge without core in init");

    a_sleep_ack_idle: assert property (@(posedge clk_sys) // [RULE_12]
        disable iff (rst)
        $rose(sleepAck) |-> $past(busIdle && sleepReq))
        else $error("Sleep acknowledged on a busy bus");

    a_read_slot: assert property (@(posedge clk_sys) disable iff (rst)
        !$past(regRead) |-> regRdData == RST_DATA)
        else $error("Read data outside its slot");

endmodule : cic_top

/* File: testbench/cic_core_model.sv */
// Behavioural model of the protocol core that faces the control block
module cic_core_model (
    // Clock and reset
    input wire logic clk_sys,
    input wire logic rst,
    // Controls from the bench
    input wire logic initWanted,
    input wire logic busBusy,
    // Core status
    output logic coreInInit,
    output logic busIdle
);
    timeunit 1ns;
    timeprecision 1ps;

    logic [2:0] syncDelay;

    // ==========================================================
    // Init entry crosses a slower domain, so it is reported late
    always @(posedge clk_sys) begin
        if (rst || !initWanted) begin
            syncDelay <= 3'h0;
        end else begin
            syncDelay <= {syncDelay[1:0], 1'b1};
        end
    end
    assign coreInInit = syncDelay[2];

    // ==========================================================
    // Bus is idle only while no frame is under way
    assign busIdle = !busBusy;
endmodule : cic_core_model

/* File: testbench/tb.sv */
// Self-checking bench for the CAN interrupt and mode control block
`define CHK(got, exp) begin checked++; if ((got) !== (exp)) begin \
    n_errors++; $display("unexpected at %0t: %h vs %h", $time, got, exp); \
    end end
`define WAITFOR(c) for (w = 0; w < 100 && !(c); w++) @(posedge clk_sys);
module tb
    import cic_pkg::*;
;
    timeunit 1ns;
    timeprecision 1ps;

    logic clk_sys = 0;
    logic rst = 1;
    logic [ADDR_W-1:0] regAddr = '0;
    logic [DATA_W-1:0] regWrData = '0;
    logic regWrite = 0;
    logic regRead = 0;
    logic [DATA_W-1:0] regRdData;
    logic rxFifoFull = 0;
    logic rxFifoOverrun = 0;
    logic [TX_BUFS-1:0] txBufEmpty = '0;
    logic [8:0] txErrCount = '0;
    logic [7:0] rxErrCount = '0;
    logic busIdle, busActivity = 0, coreInInit, powerDown = 0;
    logic moduleEnable, initModeActive, sleepModeActive;
    logic irqWake, irqError, irqRx, irqTx, wakeFromPowerDown;
    logic initWanted = 1;
    logic busBusy = 0;
    logic rdPend = 0;
    logic [7:0] expRd;
    logic [7:0] expQ[$];
    int n_errors = 0, checked = 0, cycles = 0, w, i;
    int seed = 32'h00ed_a830;
    logic [8:0] tx;
    logic [7:0] rx;
    logic [1:0] txSt, rxSt;

    cic_top DUT (.clk_sys(clk_sys), .rst(rst), .regAddr(regAddr),
        .regWrData(regWrData), .regWrite(regWrite), .regRead(regRead),
        .regRdData(regRdData), .rxFifoFull(rxFifoFull),
        .rxFifoOverrun(rxFifoOverrun), .txBufEmpty(txBufEmpty),
        .txErrCount(txErrCount), .rxErrCount(rxErrCount),
        .busIdle(busIdle), .busActivity(busActivity),
        .coreInInit(coreInInit), .powerDown(powerDown),
        .moduleEnable(moduleEnable), .initModeActive(initModeActive),
        .sleepModeActive(sleepModeActive), .irqWake(irqWake),
        .irqError(irqError), .irqRx(irqRx), .irqTx(irqTx),
        .wakeFromPowerDown(wakeFromPowerDown));
    cic_core_model core (.clk_sys(clk_sys), .rst(rst),
        .initWanted(initWanted), .busBusy(busBusy),
        .coreInInit(coreInInit), .busIdle(busIdle));

    initial begin
        forever #5 clk_sys = ~clk_sys;
    end

    // ==========================================================
    // Register bus tasks
    task automatic wr(input logic [2:0] a, input logic [7:0] d);
        @(posedge clk_sys);
        regAddr <= a;
        regWrData <= d;
        regWrite <= 1;
        @(posedge clk_sys);
        regWrite <= 0;
    endtask : wr
    task automatic rd(input logic [2:0] a, input logic [7:0] e);
        @(posedge clk_sys);
        expQ.push_back(e);
        regAddr <= a;
        regRead <= 1;
        @(posedge clk_sys);
        regRead <= 0;
    endtask : rd
    task automatic settle();
        repeat (3) @(posedge clk_sys);
    endtask : settle
    task automatic complete_run();
        if (n_errors == 0 && checked > 0) begin
            $display("Run complete: PASS");
        end else begin
            $display("Run complete: FAIL");
        end
        $finish;
    endtask : complete_run

    // ==========================================================
    // Read data checker: the oldest note meets the answer
    always @(posedge clk_sys) begin
        if (rdPend) begin
            expRd = expQ.pop_front();
            `CHK(regRdData, expRd)
        end
        rdPend <= regRead;
    end
    always @(posedge clk_sys) begin
        cycles++;
        if (cycles == 20000) begin
            n_errors++;
            complete_run();
        end
    end

    // ==========================================================
    // Main sequence
    initial begin
        repeat (8) @(posedge clk_sys);
        rst <= 0;
        rd(OFF_CTRL0, 8'h01);
        // Start-up: enable, wait for init, then leave it
        wr(OFF_CTRL1, 8'h80);
        `WAITFOR(initModeActive === 1'b1)
        rd(OFF_CTRL1, 8'h81);
        wr(OFF_CTRL0, 8'h00);
        initWanted <= 0;
        `WAITFOR(initModeActive === 1'b0)
        `CHK(moduleEnable, 1'b1)
        // Overrun while masked, then unmasked, then clears
        rxFifoOverrun <= 1;
        settle();
        `CHK(irqError, 1'b0)
        wr(OFF_RIER, 8'h02);
        wr(OFF_RFLG, 8'h02);
        settle();
        `CHK(irqError, 1'b1)
        rd(OFF_RFLG, 8'h02);
        rxFifoOverrun <= 0;
        wr(OFF_RFLG, 8'h00);
        settle();
        `CHK(irqError, 1'b1)
        wr(OFF_RFLG, 8'h02);
        settle();
        `CHK(irqError, 1'b0)
        // Error state changes on each counter and band
        wr(OFF_RIER, 8'h40);
        for (i = 0; i < 6; i++) begin
            tx = (i == 0) ? CNT_WARN : (i == 1) ? CNT_PASSIVE :
                (i == 2) ? CNT_BUSOFF : 9'h000;
            rx = (i == 3) ? 8'h60 : (i == 4) ? 8'h80 : 8'h00;
            if (tx != 0) tx = tx + 9'($random(seed) & 15);
            if (rx != 0) rx = rx + 8'($random(seed) & 15);
            txSt = (i < 3) ? 2'(i + 1) : 2'b00;
            rxSt = (i == 3) ? 2'b01 : (i == 4) ? 2'b10 : 2'b00;
            txErrCount <= tx;
            rxErrCount <= rx;
            settle();
            `CHK(irqError, (i < 5))
            rd(OFF_RFLG, {1'b0, i < 5, rxSt, txSt, 2'b00});
            wr(OFF_RFLG, 8'h40);
            rd(OFF_RFLG, {2'b00, rxSt, txSt, 2'b00});
        end
        // Receive and transmit interrupts from their own flags
        wr(OFF_RIER, 8'h01);
        wr(OFF_TIER, 8'h05);
        rxFifoFull <= 1;
        txBufEmpty <= 3'b101;
        settle();
        `CHK({irqRx, irqTx}, 2'b11)
        rd(OFF_TFLG, 8'h05);
        wr(OFF_TFLG, 8'h05);
        settle();
        `CHK(irqTx, 1'b1)
        txBufEmpty <= 3'b000;
        rxFifoFull <= 0;
        wr(OFF_TFLG, 8'h04);
        rd(OFF_TFLG, 8'h01);
        wr(OFF_TFLG, 8'h01);
        wr(OFF_RFLG, 8'h01);
        settle();
        `CHK({irqRx, irqTx}, 2'b00)
        // Sleep waits for an idle bus
        busBusy <= 1;
        wr(OFF_CTRL0, 8'h06);
        repeat (10) @(posedge clk_sys);
        `CHK(sleepModeActive, 1'b0)
        busBusy <= 0;
        `WAITFOR(sleepModeActive === 1'b1)
        rd(OFF_CTRL1, 8'h82);
        // Reconfigure from sleep through init
        wr(OFF_CTRL0, 8'h07);
        initWanted <= 1;
        `CHK(initModeActive, 1'b0)
        `WAITFOR(initModeActive === 1'b1)
        `CHK(coreInInit, 1'b1)
        wr(OFF_CTRL0, 8'h04);
        initWanted <= 0;
        `WAITFOR(initModeActive === 1'b0)
        rd(OFF_RIER, 8'h00);
        // Wake from power down out of sleep
        wr(OFF_RIER, 8'h80);
        wr(OFF_CTRL0, 8'h06);
        `WAITFOR(sleepModeActive === 1'b1)
        powerDown <= 1;
        busActivity <= 1;
        `WAITFOR(wakeFromPowerDown === 1'b1)
        `CHK(wakeFromPowerDown, 1'b1)
        `CHK(irqWake, 1'b1)
        busActivity <= 0;
        powerDown <= 0;
        settle();
        `CHK(sleepModeActive, 1'b0)
        wr(OFF_RFLG, 8'h80);
        settle();
        `CHK(irqWake, 1'b0)
        // Activity during power down while awake must not wake
        powerDown <= 1;
        busActivity <= 1;
        settle();
        `CHK(wakeFromPowerDown, 1'b0)
        busActivity <= 0;
        powerDown <= 0;
        rd(3'h7, 8'h00);
        settle();
        complete_run();
    end
endmodule : tb
